// ===== include/lmd_params.svh
// constants of the logic and move datapath
`ifndef LMD_PARAMS_SVH
`define LMD_PARAMS_SVH
`define LMD_DATA_W   32
`define LMD_HALF_W   16
`define LMD_NREG     8
`define LMD_RSEL_W   3
`define LMD_ADDR_W   32
`define LMD_WORD_RST 32'h0000_0000
`define LMD_WORD_ONE 32'h0000_0001
`endif

// ===== include/lmd_pkg.sv
// types of the logic and move datapath
`include "lmd_params.svh"
package lmd_pkg;
  typedef enum logic [4:0] {
    OP_AND_FULL, OP_OR_FULL, OP_XOR_FULL,
    OP_AND_HALF, OP_OR_HALF, OP_XOR_HALF,
    OP_BOOL_CC, OP_BOOL_REG, OP_BOOL_HALF, OP_BOOL_FLOAT,
    OP_SET_FALSE, OP_SET_TRUE,
    OP_SWAP_REG_MEM_FULL, OP_SWAP_REG_MEM_HALF,
    OP_SWAP_HALVES, OP_SWAP_HALVES_CLEAR_HI, OP_SWAP_HALVES_CLEAR_LO,
    OP_SWAP_BYTES, OP_SWAP_BYTES_CLEAR_HI, OP_SWAP_BYTES_CLEAR_LO,
    OP_STORE_FULL, OP_STORE_HALF, OP_COND_STORE_FULL, OP_COND_STORE_HALF,
    OP_LOAD_FULL, OP_LOAD_HALF, OP_LOAD_HALF_SHIFT_ONE, OP_LOAD_HALF_SHIFT_TWO
  } lmd_op_t;
  typedef enum logic [2:0] {
    REL_LT, REL_LE, REL_EQ, REL_NE, REL_GE, REL_GT
  } lmd_rel_t;
  typedef struct packed {
    lmd_op_t                  op;
    lmd_rel_t                 rel;
    logic [`LMD_RSEL_W-1:0]   rsel;
    logic [`LMD_ADDR_W-1:0]   effective_address;
  } lmd_req_t;
  typedef struct packed {
    logic                     lt;
    logic                     eq;
  } lmd_cc_t;
  typedef struct packed {
    logic                     rd;
    logic                     wr;
    logic                     half;
    logic [`LMD_ADDR_W-1:0]   addr;
    logic [`LMD_DATA_W-1:0]   wdata;
  } lmd_mem_t;
endpackage : lmd_pkg

// ===== core/lmd_core.sv
// logic, logicize and move datapath with its general registers
`timescale 1ns/1ps
`default_nettype none
`include "lmd_params.svh"
module lmd_core (
  input  wire logic                    ref_clk_in,
  input  wire logic                    resetn_in,
  input  wire logic                    ce_in,
  input  wire logic                    req_valid_in,
  input  wire lmd_pkg::lmd_req_t       req_in,
  output var  logic                    req_ready_out,
  output var  logic                    done_out,
  input  wire lmd_pkg::lmd_cc_t        condition_codes_in,
  input  wire logic [`LMD_DATA_W-1:0]  float_acc_in,
  output var  lmd_pkg::lmd_mem_t       mem_out,
  input  wire logic                    mem_ack_in,
  input  wire logic [`LMD_DATA_W-1:0]  mem_rdata_in,
  input  wire logic [`LMD_RSEL_W-1:0]  view_sel_in,
  output var  logic [`LMD_DATA_W-1:0]  view_data_out
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_EXEC, ST_WRITE, ST_DONE
  } lmd_state_t;

  lmd_state_t               state_reg, state_next;
  lmd_pkg::lmd_req_t        req_reg, req_next;
  lmd_pkg::lmd_mem_t        mem_reg, mem_next;
  logic [`LMD_DATA_W-1:0]   regs_reg [`LMD_NREG];
  logic [`LMD_DATA_W-1:0]   regs_next [`LMD_NREG];
  logic [`LMD_DATA_W-1:0]   opnd_reg, opnd_next;
  logic [`LMD_DATA_W-1:0]   view_reg, view_next;
  logic                     ready_reg, ready_next;
  logic                     done_reg, done_next;

  ////////////////////////////////////////////////////////////////////////////
  // operand views; bit 31 is the msb, so the high half is [31:16]
  logic [`LMD_RSEL_W-1:0]   rsel_nxt;
  logic [`LMD_DATA_W-1:0]   cur_r;
  logic [`LMD_DATA_W-1:0]   nxt_r;
  logic [`LMD_HALF_W-1:0]   r_hi;
  logic [`LMD_HALF_W-1:0]   r_lo;
  logic [`LMD_HALF_W-1:0]   m_half;

  assign rsel_nxt = req_reg.rsel + 3'h1;
  assign cur_r    = regs_reg[req_reg.rsel];
  assign nxt_r    = regs_reg[rsel_nxt];
  assign r_hi     = cur_r[31:16];
  assign r_lo     = cur_r[15:0];
  assign m_half   = opnd_reg[15:0];

  function automatic logic rel_holds(lmd_pkg::lmd_rel_t rel, logic neg, logic zero);
    logic res;
    res = 1'b0;
    unique case (rel)
      lmd_pkg::REL_LT: res = neg;
      lmd_pkg::REL_LE: res = neg | zero;
      lmd_pkg::REL_EQ: res = zero;
      lmd_pkg::REL_NE: res = ~zero;
      lmd_pkg::REL_GE: res = ~neg;
      lmd_pkg::REL_GT: res = ~neg & ~zero;
      default:         res = 1'b0;
    endcase
    return res;
  endfunction : rel_holds

  function automatic logic needs_read(lmd_pkg::lmd_op_t op);
    logic res;
    res = 1'b0;
    unique case (op)
      lmd_pkg::OP_AND_FULL, lmd_pkg::OP_OR_FULL, lmd_pkg::OP_XOR_FULL,
      lmd_pkg::OP_AND_HALF, lmd_pkg::OP_OR_HALF, lmd_pkg::OP_XOR_HALF,
      lmd_pkg::OP_SWAP_REG_MEM_FULL, lmd_pkg::OP_SWAP_REG_MEM_HALF,
      lmd_pkg::OP_COND_STORE_FULL, lmd_pkg::OP_COND_STORE_HALF,
      lmd_pkg::OP_LOAD_FULL, lmd_pkg::OP_LOAD_HALF,
      lmd_pkg::OP_LOAD_HALF_SHIFT_ONE, lmd_pkg::OP_LOAD_HALF_SHIFT_TWO: res = 1'b1;
      default: res = 1'b0;
    endcase
    return res;
  endfunction : needs_read

  function automatic logic is_half(lmd_pkg::lmd_op_t op);
    logic res;
    res = 1'b0;
    unique case (op)
      lmd_pkg::OP_AND_HALF, lmd_pkg::OP_OR_HALF, lmd_pkg::OP_XOR_HALF,
      lmd_pkg::OP_SWAP_REG_MEM_HALF, lmd_pkg::OP_STORE_HALF,
      lmd_pkg::OP_COND_STORE_HALF, lmd_pkg::OP_LOAD_HALF,
      lmd_pkg::OP_LOAD_HALF_SHIFT_ONE, lmd_pkg::OP_LOAD_HALF_SHIFT_TWO: res = 1'b1;
      default: res = 1'b0;
    endcase
    return res;
  endfunction : is_half

  ////////////////////////////////////////////////////////////////////////////
  // execute: register result and memory write for the held request
  // condition codes are only read here, never driven
  logic                     res_we;
  logic [`LMD_DATA_W-1:0]   res_val;
  logic                     mw_en;
  logic [`LMD_DATA_W-1:0]   mw_data;
  logic                     test_ok;

  always_comb begin
    res_we  = 1'b1;
    res_val = cur_r;
    mw_en   = 1'b0;
    mw_data = cur_r;
    test_ok = 1'b0;
    unique case (req_reg.op)
      lmd_pkg::OP_AND_FULL: res_val = cur_r & opnd_reg;
      lmd_pkg::OP_OR_FULL:  res_val = cur_r | opnd_reg;
      lmd_pkg::OP_XOR_FULL: res_val = cur_r ^ opnd_reg;
      lmd_pkg::OP_AND_HALF: res_val = {r_hi & m_half, r_lo};
      lmd_pkg::OP_OR_HALF:  res_val = {r_hi | m_half, r_lo};
      lmd_pkg::OP_XOR_HALF: res_val = {r_hi ^ m_half, r_lo};
      lmd_pkg::OP_BOOL_CC, lmd_pkg::OP_BOOL_REG,
      lmd_pkg::OP_BOOL_HALF, lmd_pkg::OP_BOOL_FLOAT: begin
        unique case (req_reg.op)
          lmd_pkg::OP_BOOL_CC: test_ok = rel_holds(req_reg.rel,
            condition_codes_in.lt, condition_codes_in.eq);
          lmd_pkg::OP_BOOL_REG: test_ok = rel_holds(req_reg.rel,
            cur_r[31], cur_r == `LMD_WORD_RST);
          lmd_pkg::OP_BOOL_HALF: test_ok = rel_holds(req_reg.rel,
            r_hi[15], r_hi == 16'h0000);
          default: test_ok = rel_holds(req_reg.rel,
            float_acc_in[31], float_acc_in == `LMD_WORD_RST);
        endcase
        res_val = test_ok ? `LMD_WORD_ONE : `LMD_WORD_RST;
      end
      lmd_pkg::OP_SET_FALSE: res_val = `LMD_WORD_RST;
      lmd_pkg::OP_SET_TRUE:  res_val = `LMD_WORD_ONE;
      lmd_pkg::OP_SWAP_REG_MEM_FULL: begin
        res_val = opnd_reg;
        mw_en   = 1'b1;
        mw_data = cur_r;
      end
      lmd_pkg::OP_SWAP_REG_MEM_HALF: begin
        res_val = {m_half, r_lo};
        mw_en   = 1'b1;
        mw_data = {16'h0000, r_hi};
      end
      lmd_pkg::OP_SWAP_HALVES:          res_val = {r_lo, r_hi};
      lmd_pkg::OP_SWAP_HALVES_CLEAR_HI: res_val = {16'h0000, r_hi};
      lmd_pkg::OP_SWAP_HALVES_CLEAR_LO: res_val = {r_lo, 16'h0000};
      lmd_pkg::OP_SWAP_BYTES:   res_val = {r_hi[7:0], r_hi[15:8], r_lo};
      lmd_pkg::OP_SWAP_BYTES_CLEAR_HI: res_val = {8'h00, r_hi[15:8], r_lo};
      lmd_pkg::OP_SWAP_BYTES_CLEAR_LO: res_val = {r_hi[7:0], 8'h00, r_lo};
      lmd_pkg::OP_STORE_FULL: begin
        res_we = 1'b0;
        mw_en  = 1'b1;
      end
      lmd_pkg::OP_STORE_HALF: begin
        res_we  = 1'b0;
        mw_en   = 1'b1;
        mw_data = {16'h0000, r_hi};
      end
      lmd_pkg::OP_COND_STORE_FULL: begin
        res_we = 1'b0;
        mw_en  = (nxt_r == opnd_reg);
      end
      lmd_pkg::OP_COND_STORE_HALF: begin
        res_we  = 1'b0;
        mw_en   = (r_lo == m_half);
        mw_data = {16'h0000, r_hi};
      end
      lmd_pkg::OP_LOAD_FULL: res_val = opnd_reg;
      lmd_pkg::OP_LOAD_HALF: res_val = {m_half, r_lo};
      lmd_pkg::OP_LOAD_HALF_SHIFT_ONE: res_val = {m_half[14:0], 1'b0, r_lo};
      lmd_pkg::OP_LOAD_HALF_SHIFT_TWO: res_val = {m_half[13:0], 2'b00, r_lo};
      default: res_we = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing; memory request is a level held until the acknowledge
  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    mem_next   = mem_reg;
    regs_next  = regs_reg;
    opnd_next  = opnd_reg;
    ready_next = ready_reg;
    done_next  = 1'b0;
    view_next  = regs_reg[view_sel_in];
    unique case (state_reg)
      ST_IDLE: begin
        ready_next = 1'b1;
        if (req_valid_in && ready_reg) begin
          req_next      = req_in;
          ready_next    = 1'b0;
          mem_next.half = is_half(req_in.op);
          mem_next.addr = req_in.effective_address;
          if (needs_read(req_in.op)) begin
            mem_next.rd = 1'b1;
            state_next  = ST_READ;
          end else begin
            state_next = ST_EXEC;
          end
        end
      end
      ST_READ: begin
        if (mem_ack_in) begin
          mem_next.rd = 1'b0;
          opnd_next   = mem_rdata_in;
          state_next  = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (res_we) begin
          regs_next[req_reg.rsel] = res_val;
        end
        if (mw_en) begin
          mem_next.wr    = 1'b1;
          mem_next.wdata = mw_data;
          state_next     = ST_WRITE;
        end else begin
          state_next = ST_DONE;
        end
      end
      ST_WRITE: begin
        if (mem_ack_in) begin
          mem_next.wr = 1'b0;
          state_next  = ST_DONE;
        end
      end
      ST_DONE: begin
        done_next  = 1'b1;
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  // registers are cleared by the synchronous reset so a read before any load is defined
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      req_reg   <= '0;
      mem_reg   <= '0;
      opnd_reg  <= `LMD_WORD_RST;
      view_reg  <= `LMD_WORD_RST;
      ready_reg <= 1'b0;
      done_reg  <= 1'b0;
      for (int i = 0; i < `LMD_NREG; i++) begin
        regs_reg[i] <= `LMD_WORD_RST;
      end
    end else if (ce_in) begin
      state_reg <= state_next;
      req_reg   <= req_next;
      mem_reg   <= mem_next;
      opnd_reg  <= opnd_next;
      view_reg  <= view_next;
      ready_reg <= ready_next;
      done_reg  <= done_next;
      regs_reg  <= regs_next;
    end
  end

  assign req_ready_out = ready_reg;
  assign done_out      = done_reg;
  assign mem_out       = mem_reg;
  assign view_data_out = view_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  logic fire;
  assign fire = ce_in && state_reg == ST_EXEC;

  a_and_full: assert property (fire && req_reg.op == lmd_pkg::OP_AND_FULL
    |=> regs_reg[req_reg.rsel] == ($past(cur_r) & $past(opnd_reg)))
    else $error("fullword and result wrong");
  a_xor_half: assert property (fire && req_reg.op == lmd_pkg::OP_XOR_HALF
    |=> regs_reg[req_reg.rsel] == {$past(r_hi) ^ $past(m_half), $past(r_lo)})
    else $error("halfword xor result wrong");
  a_bool_value: assert property (fire && req_reg.op == lmd_pkg::OP_BOOL_REG
    && req_reg.rel == lmd_pkg::REL_EQ
    |=> regs_reg[req_reg.rsel] == {31'h0, ($past(cur_r) == 32'h0)})
    else $error("logicize value wrong");
  a_bool_neg: assert property (fire && req_reg.op == lmd_pkg::OP_BOOL_HALF
    && req_reg.rel == lmd_pkg::REL_LT && r_hi[15] |=> regs_reg[req_reg.rsel] == 32'h1)
    else $error("half sign test wrong");
  a_set_true: assert property (fire && req_reg.op == lmd_pkg::OP_SET_TRUE
    |=> regs_reg[req_reg.rsel] == 32'h1 ##1 done_out)
    else $error("set true wrong");
  a_swap_full: assert property (fire && req_reg.op == lmd_pkg::OP_SWAP_REG_MEM_FULL
    |=> mem_out.wr && mem_out.wdata == $past(cur_r) && regs_reg[req_reg.rsel] == $past(opnd_reg))
    else $error("fullword interchange wrong");
  a_swap_bytes: assert property (fire && req_reg.op == lmd_pkg::OP_SWAP_BYTES
    |=> regs_reg[req_reg.rsel] == {$past(cur_r[23:16]), $past(cur_r[31:24]), $past(r_lo)})
    else $error("byte interchange wrong");
  a_cs_skip: assert property (fire && req_reg.op == lmd_pkg::OP_COND_STORE_FULL
    && nxt_r != opnd_reg |=> !mem_out.wr ##1 done_out)
    else $error("conditional store wrote on mismatch");
  a_shift_two: assert property (fire && req_reg.op == lmd_pkg::OP_LOAD_HALF_SHIFT_TWO
    |=> regs_reg[req_reg.rsel][31:16] == {$past(m_half[13:0]), 2'b00})
    else $error("shifted load wrong");
  a_read_hold: assert property (mem_out.rd && !mem_ack_in && ce_in |=> mem_out.rd)
    else $error("read request dropped before ack");

  c_swap_mem: cover property (fire && req_reg.op == lmd_pkg::OP_SWAP_REG_MEM_HALF);
  c_cs_hit: cover property (fire && req_reg.op == lmd_pkg::OP_COND_STORE_HALF && mw_en);
  c_bool_cc: cover property (fire && req_reg.op == lmd_pkg::OP_BOOL_CC && test_ok);
endmodule : lmd_core
`default_nettype wire

// ===== sim/lmd_mem_model.sv
// behavioural memory on the far side of the datapath
`timescale 1ns/1ps
`default_nettype none
`include "lmd_params.svh"
module lmd_mem_model (
  input  wire logic                   ref_clk_in,
  input  wire logic                   resetn_in,
  input  wire logic                   slow_in,
  input  wire lmd_pkg::lmd_mem_t      mem_in,
  output var  logic                   mem_ack_out,
  output var  logic [`LMD_DATA_W-1:0] mem_rdata_out
);
  logic [`LMD_DATA_W-1:0] mem [0:15];
  logic [2:0]             wait_reg;
  // read data toggles outside the ack cycle so a stale sample is never a match
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      mem_ack_out <= 1'b0;
      wait_reg <= 3'h0;
      mem_rdata_out <= 32'h5a5a_a5a5;
    end else if (mem_ack_out) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
    end else if (mem_in.rd || mem_in.wr) begin
      if (wait_reg == (slow_in ? 3'h3 : 3'h0)) begin
        wait_reg <= 3'h0;
        mem_ack_out <= 1'b1;
        mem_rdata_out <= {~mem_rdata_out[31:16], mem[mem_in.addr[3:0]][15:0]};
        if (mem_in.rd && !mem_in.half) mem_rdata_out <= mem[mem_in.addr[3:0]];
        if (mem_in.wr && mem_in.half) mem[mem_in.addr[3:0]][15:0] <= mem_in.wdata[15:0];
        if (mem_in.wr && !mem_in.half) mem[mem_in.addr[3:0]] <= mem_in.wdata;
      end else begin
        wait_reg <= wait_reg + 3'h1;
        mem_rdata_out <= ~mem_rdata_out;
      end
    end else begin
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule : lmd_mem_model
`default_nettype wire

// ===== sim/tb_logic_move_datapath.sv
// self-checking bench for the logic and move datapath
`timescale 1ns/1ps
`default_nettype none
`include "lmd_params.svh"
module tb_logic_move_datapath;
  typedef struct {
    lmd_pkg::lmd_op_t op;
    logic [31:0]      r, m, er, em;
  } lmd_row_t;
  logic ref_clk_in, resetn_in, ce_in, req_valid_in, req_ready_out, done_out;
  logic mem_ack, slow, exp_b;
  lmd_pkg::lmd_req_t req_in;
  lmd_pkg::lmd_cc_t  condition_codes_in;
  lmd_pkg::lmd_mem_t mem_out;
  logic [31:0] float_acc_in, mem_rdata, view_data_out, got, val;
  logic [2:0]  view_sel_in;
  int bad_count = 0;
  int n_checks = 0;
  logic [31:0] vals [5] = '{32'h8000_0000, 32'h0, 32'h0000_8000, 32'h0001_0000, 32'hffff_0001};
  lmd_pkg::lmd_op_t bops [4] = '{lmd_pkg::OP_BOOL_CC, lmd_pkg::OP_BOOL_REG,
                                 lmd_pkg::OP_BOOL_HALF, lmd_pkg::OP_BOOL_FLOAT};
  lmd_row_t rows [22] = '{
    '{lmd_pkg::OP_AND_FULL, 32'hf0f0_1234, 32'hff00_0f0f, 32'hf000_0204, 32'hff00_0f0f},
    '{lmd_pkg::OP_OR_FULL, 32'hf0f0_1234, 32'h0f00_0001, 32'hfff0_1235, 32'h0f00_0001},
    '{lmd_pkg::OP_XOR_FULL, 32'hffff_0000, 32'h1234_5678, 32'hedcb_5678, 32'h1234_5678},
    '{lmd_pkg::OP_AND_HALF, 32'hf0f0_1234, 32'h0000_0ff0, 32'h00f0_1234, 32'h0000_0ff0},
    '{lmd_pkg::OP_OR_HALF, 32'h1200_abcd, 32'hffff_0034, 32'h1234_abcd, 32'hffff_0034},
    '{lmd_pkg::OP_XOR_HALF, 32'hffff_0001, 32'h0000_00ff, 32'hff00_0001, 32'h0000_00ff},
    '{lmd_pkg::OP_SET_FALSE, 32'h1234_5678, 32'h1, 32'h0, 32'h1},
    '{lmd_pkg::OP_SET_TRUE, 32'h1234_5678, 32'h0, 32'h1, 32'h0},
    '{lmd_pkg::OP_SWAP_REG_MEM_FULL, 32'h1234_5678, 32'h9abc_def0, 32'h9abc_def0, 32'h1234_5678},
    '{lmd_pkg::OP_SWAP_REG_MEM_HALF, 32'h1234_5678, 32'hffff_9abc, 32'h9abc_5678, 32'hffff_1234},
    '{lmd_pkg::OP_SWAP_HALVES, 32'h1234_5678, 32'h0, 32'h5678_1234, 32'h0},
    '{lmd_pkg::OP_SWAP_HALVES_CLEAR_HI, 32'h1234_5678, 32'h0, 32'h0000_1234, 32'h0},
    '{lmd_pkg::OP_SWAP_HALVES_CLEAR_LO, 32'h1234_5678, 32'h0, 32'h5678_0000, 32'h0},
    '{lmd_pkg::OP_SWAP_BYTES, 32'h1234_5678, 32'h0, 32'h3412_5678, 32'h0},
    '{lmd_pkg::OP_SWAP_BYTES_CLEAR_HI, 32'h1234_5678, 32'h0, 32'h0012_5678, 32'h0},
    '{lmd_pkg::OP_SWAP_BYTES_CLEAR_LO, 32'h1234_5678, 32'h0, 32'h3400_5678, 32'h0},
    '{lmd_pkg::OP_STORE_FULL, 32'h1234_5678, 32'h0, 32'h1234_5678, 32'h1234_5678},
    '{lmd_pkg::OP_STORE_HALF, 32'h1234_5678, 32'hffff_ffff, 32'h1234_5678, 32'hffff_1234},
    '{lmd_pkg::OP_LOAD_FULL, 32'h0, 32'hcafe_f00d, 32'hcafe_f00d, 32'hcafe_f00d},
    '{lmd_pkg::OP_LOAD_HALF, 32'h1111_2222, 32'hffff_abcd, 32'habcd_2222, 32'hffff_abcd},
    '{lmd_pkg::OP_LOAD_HALF_SHIFT_ONE, 32'h1111_2222, 32'h0000_c001, 32'h8002_2222, 32'h0000_c001},
    '{lmd_pkg::OP_LOAD_HALF_SHIFT_TWO, 32'h1111_2222, 32'h0000_6003, 32'h800c_2222, 32'h0000_6003}};

  lmd_core dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
    .done_out(done_out), .condition_codes_in(condition_codes_in),
    .float_acc_in(float_acc_in), .mem_out(mem_out), .mem_ack_in(mem_ack),
    .mem_rdata_in(mem_rdata), .view_sel_in(view_sel_in), .view_data_out(view_data_out));
  lmd_mem_model u_mem (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .slow_in(slow),
    .mem_in(mem_out), .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata));

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // entered at a falling edge; request held until the edge that sees ready
  task automatic run_op(input lmd_pkg::lmd_op_t op, input int rel, input logic [2:0] rs,
                        input logic [31:0] addr);
    int n;
    req_in = '{op, lmd_pkg::lmd_rel_t'(rel), rs, addr};
    req_valid_in = 1'b1;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 40) begin
      @(negedge ref_clk_in);
      n++;
    end
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 40) begin
      @(negedge ref_clk_in);
      n++;
    end
    check({31'h0, done_out}, 32'h1);
  endtask : run_op
  task automatic rd_reg(input logic [2:0] rs);
    view_sel_in = rs;
    @(negedge ref_clk_in);
    got = view_data_out;
  endtask : rd_reg
  task automatic set_reg(input logic [2:0] rs, input logic [31:0] v);
    u_mem.mem[15] = v;
    run_op(lmd_pkg::OP_LOAD_FULL, 0, rs, 32'hf);
  endtask : set_reg
  function automatic logic rel_ok(input int rel, input logic neg, input logic zer);
    case (rel)
      0: return neg;
      1: return neg | zer;
      2: return zer;
      3: return !zer;
      4: return !neg;
      default: return !neg && !zer;
    endcase
  endfunction : rel_ok
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    bad_count++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    {resetn_in, req_valid_in, slow, exp_b} = 4'h0;
    ce_in = 1'b1;
    req_in = '0;
    condition_codes_in = '0;
    float_acc_in = 32'h0;
    view_sel_in = 3'h0;
    repeat (10) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(i[2:0]);
      check(got, `LMD_WORD_RST);
    end
    $display("reset values done");
    // table twice: prompt memory, then a memory that waits three cycles
    for (int p = 0; p < 2; p++) begin
      slow = p[0];
      for (int i = 0; i < 22; i++) begin
        set_reg(i[2:0], rows[i].r);
        u_mem.mem[2] = rows[i].m;
        run_op(rows[i].op, 0, i[2:0], 32'h2);
        rd_reg(i[2:0]);
        check(got, rows[i].er);
        check({16'h0, got[31:16]}, {16'h0, rows[i].er[31:16]});
        check(u_mem.mem[2], rows[i].em);
      end
    end
    $display("table done");
    for (int f = 0; f < 4; f++) begin
      for (int k = 0; k < 6; k++) begin
        for (int v = 0; v < 5; v++) begin
          val = vals[v];
          set_reg(3'h3, val);
          float_acc_in = val;
          condition_codes_in = {val[31], val == 32'h0};
          exp_b = rel_ok(k, val[31], (f == 2) ? (val[31:16] == 16'h0) : (val == 32'h0));
          run_op(bops[f], k, 3'h3, 32'h2);
          rd_reg(3'h3);
          check(got, {31'h0, exp_b});
        end
      end
    end
    $display("logicize done");
    for (int e = 0; e < 2; e++) begin
      set_reg(3'h7, 32'haaaa_5555);
      set_reg(3'h0, 32'h1357_9bdf);
      u_mem.mem[2] = 32'h1357_9bdf + e;
      run_op(lmd_pkg::OP_COND_STORE_FULL, 0, 3'h7, 32'h2);
      check(u_mem.mem[2], (e == 0) ? 32'haaaa_5555 : 32'h1357_9be0);
      set_reg(3'h5, 32'habcd_1234);
      u_mem.mem[2] = 32'hffff_1234 + e;
      run_op(lmd_pkg::OP_COND_STORE_HALF, 0, 3'h5, 32'h2);
      check(u_mem.mem[2], (e == 0) ? 32'hffff_abcd : 32'hffff_1235);
    end
    $display("conditional stores done");
    // a request offered while the enable is low must not be taken
    set_reg(3'h4, 32'h0);
    ce_in = 1'b0;
    req_in = '{lmd_pkg::OP_SET_TRUE, lmd_pkg::REL_LT, 3'h4, 32'h0};
    req_valid_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    check({31'h0, done_out}, 32'h1);
    req_valid_in = 1'b0;
    ce_in = 1'b1;
    rd_reg(3'h4);
    check(got, `LMD_WORD_RST);
    $display("clock enable done");
    set_reg(3'h1, 32'hffff_ffff);
    resetn_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    check({31'h0, req_ready_out}, 32'h0);
    check({30'h0, mem_out.rd, mem_out.wr}, 32'h0);
    resetn_in = 1'b1;
    rd_reg(3'h1);
    check(got, `LMD_WORD_RST);
    $display("second reset done");
    report_and_stop();
  end
endmodule : tb_logic_move_datapath
`default_nettype wire
